/* hdl/irq_ctrl_pkg.sv */
// constants and types for the interrupt enable and flag block
package irq_ctrl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] INTERRUPT_CONTROL_ADDR           = 8'h0B;
  localparam logic [7:0] INTERRUPT_CONTROL_ALT_ADDR       = 8'h8B;
  localparam logic [7:0] PERIPHERAL_INTERRUPT_ENABLE_ADDR = 8'h8C;
  localparam logic [7:0] PERIPHERAL_FLAG_ADDR             = 8'h0C;
  localparam logic [7:0] PIN_CHANGE_SELECT_ADDR           = 8'h96;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int GLOBAL_EN_BIT   = 7;
  localparam int PERIPH_EN_BIT   = 6;
  localparam int TICK0_EN_BIT    = 5;
  localparam int EXT_EN_BIT      = 4;
  localparam int PORT_EN_BIT     = 3;
  localparam int TICK0_FLAG_BIT  = 2;
  localparam int EXT_FLAG_BIT    = 1;
  localparam int PORT_FLAG_BIT   = 0;
  localparam int NVM_BIT         = 7;
  localparam int CONV_BIT        = 6;
  localparam int CMP_BIT         = 3;
  localparam int TICK1_BIT       = 0;
  localparam logic [7:0] PERIPH_IMPL_MASK = 8'hC9;
  localparam logic [7:0] REG_RESET        = 8'h00;

  // ----------------------------------------------------------------
  // bus carrier and event bundle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

  typedef struct packed {
    logic tick0_overflow;
    logic ext_edge;
    logic nvm_write_done;
    logic converter_done;
    logic comparator_change;
    logic tick1_overflow;
  } irq_event_type;

endpackage

/* hdl/interrupt_enable_flag_control.sv */
// interrupt enable and flag register block with combined request
`timescale 1ns/100ps
module interrupt_enable_flag_control
#(
  parameter int  PORT_WIDTH    = 6,
  parameter bit  HAS_CONVERTER = 1'b1
)
(
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_n_in,
  input  wire irq_ctrl_pkg::reg_req_type  reg_req_in,
  output      logic [7:0]                 reg_rdata_out,
  input  wire irq_ctrl_pkg::irq_event_type events_in,
  input  wire logic [PORT_WIDTH-1:0]      port_pins_in,
  output      logic                       irq_out
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (PORT_WIDTH < 1 || PORT_WIDTH > 8)
  begin : g_bad_width
    $error("port width must be 1 to 8");
  end

  logic [7:0]            interrupt_control_q;
  logic [7:0]            peripheral_interrupt_enable_q;
  logic [7:0]            periph_flag_q;
  logic [PORT_WIDTH-1:0] pin_change_select_q;
  logic [PORT_WIDTH-1:0] port_last_q;
  logic                  port_seen_q;
  logic                  wr_ctrl;
  logic                  wr_pie;
  logic                  wr_pfl;
  logic                  port_change;
  logic [7:0]            periph_events;
  logic                  core_req;
  logic                  periph_req;

  // address match helper for the mirrored control register
  function automatic logic is_ctrl(input logic [7:0] a);
    is_ctrl = (a == irq_ctrl_pkg::INTERRUPT_CONTROL_ADDR) ||
              (a == irq_ctrl_pkg::INTERRUPT_CONTROL_ALT_ADDR);
  endfunction

  // ----------------------------------------------------------------
  // write decode and event gathering
  // ----------------------------------------------------------------
  assign wr_ctrl = reg_req_in.wr && is_ctrl(reg_req_in.addr);
  assign wr_pie  = reg_req_in.wr &&
    (reg_req_in.addr == irq_ctrl_pkg::PERIPHERAL_INTERRUPT_ENABLE_ADDR);
  assign wr_pfl  = reg_req_in.wr &&
    (reg_req_in.addr == irq_ctrl_pkg::PERIPHERAL_FLAG_ADDR);

  // pin change seen only on selected pins after first sample
  assign port_change = port_seen_q &&
    (|((port_pins_in ^ port_last_q) & pin_change_select_q));

  // peripheral events in enable-register layout
  always_comb
  begin
    periph_events = 8'h00;
    periph_events[irq_ctrl_pkg::NVM_BIT]   = events_in.nvm_write_done;
    periph_events[irq_ctrl_pkg::CONV_BIT]  =
      events_in.converter_done & HAS_CONVERTER;
    periph_events[irq_ctrl_pkg::CMP_BIT]   = events_in.comparator_change;
    periph_events[irq_ctrl_pkg::TICK1_BIT] = events_in.tick1_overflow;
  end

  // ----------------------------------------------------------------
  // control register: enables and sticky flags, set beats clear
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      interrupt_control_q <= irq_ctrl_pkg::REG_RESET;
    else
    begin
      if (wr_ctrl)
        interrupt_control_q <= reg_req_in.wdata;
      // events override a concurrent write, enables ignored
      if (events_in.tick0_overflow)
        interrupt_control_q[irq_ctrl_pkg::TICK0_FLAG_BIT] <= 1'b1;
      if (events_in.ext_edge)
        interrupt_control_q[irq_ctrl_pkg::EXT_FLAG_BIT] <= 1'b1;
      if (port_change)
        interrupt_control_q[irq_ctrl_pkg::PORT_FLAG_BIT] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // peripheral enable register, unimplemented bits held zero
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      peripheral_interrupt_enable_q <= irq_ctrl_pkg::REG_RESET;
    else if (wr_pie)
      peripheral_interrupt_enable_q <=
        reg_req_in.wdata & irq_ctrl_pkg::PERIPH_IMPL_MASK;
  end

  // ----------------------------------------------------------------
  // peripheral flags: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      periph_flag_q <= irq_ctrl_pkg::REG_RESET;
    else if (wr_pfl)
      periph_flag_q <= ((periph_flag_q & ~reg_req_in.wdata) | periph_events)
                       & irq_ctrl_pkg::PERIPH_IMPL_MASK;
    else
      periph_flag_q <= (periph_flag_q | periph_events)
                       & irq_ctrl_pkg::PERIPH_IMPL_MASK;
  end

  // ----------------------------------------------------------------
  // per-pin change select register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pin_change_select_q <= '0;
    else if (reg_req_in.wr &&
             reg_req_in.addr == irq_ctrl_pkg::PIN_CHANGE_SELECT_ADDR)
      pin_change_select_q <= reg_req_in.wdata[PORT_WIDTH-1:0];
  end

  // ----------------------------------------------------------------
  // port level memory for change detection
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      port_last_q <= '0;
      port_seen_q <= 1'b0;
    end
    else
    begin
      port_last_q <= port_pins_in;
      port_seen_q <= 1'b1; // first sample after reset is reference only
    end
  end

  // ----------------------------------------------------------------
  // combined request to the core
  // ----------------------------------------------------------------
  assign core_req =
    |(interrupt_control_q[5:3] & interrupt_control_q[2:0]);
  assign periph_req = interrupt_control_q[irq_ctrl_pkg::PERIPH_EN_BIT] &&
    (|(peripheral_interrupt_enable_q & periph_flag_q));

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= interrupt_control_q[irq_ctrl_pkg::GLOBAL_EN_BIT] &&
                 (core_req || periph_req);
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe, zero otherwise
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= 8'h00;
    else if (!reg_req_in.rd)
      reg_rdata_out <= 8'h00;
    else if (is_ctrl(reg_req_in.addr))
      reg_rdata_out <= interrupt_control_q;
    else if (reg_req_in.addr ==
             irq_ctrl_pkg::PERIPHERAL_INTERRUPT_ENABLE_ADDR)
      reg_rdata_out <= peripheral_interrupt_enable_q;
    else if (reg_req_in.addr == irq_ctrl_pkg::PERIPHERAL_FLAG_ADDR)
      reg_rdata_out <= periph_flag_q;
    else if (reg_req_in.addr == irq_ctrl_pkg::PIN_CHANGE_SELECT_ADDR)
      reg_rdata_out <= 8'(pin_change_select_q);
    else
      reg_rdata_out <= 8'h00; // unmapped reads zero
  end

endmodule

/* verif/irq_ctrl_checker_assertions.sv */
// checker for the interrupt enable and flag block
`timescale 1ns/100ps
module irq_ctrl_checker
#(
  parameter int PORT_WIDTH    = 6,
  parameter bit HAS_CONVERTER = 1'b1
)
(
  input wire logic                        ref_clk_in,
  input wire logic                        rst_n_in,
  input wire irq_ctrl_pkg::reg_req_type   reg_req_in,
  input wire logic [7:0]                  reg_rdata_out,
  input wire irq_ctrl_pkg::irq_event_type events_in,
  input wire logic [PORT_WIDTH-1:0]       port_pins_in,
  input wire logic                        irq_out
);
  logic ctl_wr;
  logic ctl_rd;
  logic pie_wr;
  logic pie_rd;
  logic [7:0] wd;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // decoded accesses, control seen at both mirror addresses
  assign ctl_wr = reg_req_in.wr && reg_req_in.addr[6:0] == 7'h0B;
  assign ctl_rd = reg_req_in.rd && reg_req_in.addr[6:0] == 7'h0B;
  assign pie_wr = reg_req_in.wr && reg_req_in.addr == 8'h8C;
  assign pie_rd = reg_req_in.rd && reg_req_in.addr == 8'h8C;
  assign wd = reg_req_in.wdata;
  // ------------
  // register and request checks
  // ------------
  chk_read_idle: assert property (
    !reg_req_in.rd |=> reg_rdata_out == 8'h00)
    else $error("read data not zero when idle");
  chk_ctl_readback: assert property (
    ctl_wr ##1 !reg_req_in.wr ##1 ctl_rd |=>
    (reg_rdata_out & 8'hF8) == ($past(wd, 3) & 8'hF8))
    else $error("control enables read back wrong");
  chk_pie_readback: assert property (
    pie_wr ##1 !reg_req_in.wr ##1 pie_rd |=>
    reg_rdata_out == ($past(wd, 3) & 8'hC9))
    else $error("peripheral enable read back wrong");
  chk_tick0_flag: assert property (
    events_in.tick0_overflow ##1 !reg_req_in.wr ##1 ctl_rd |=>
    reg_rdata_out[2]) else $error("tick0 flag not set");
  chk_ext_flag: assert property (
    events_in.ext_edge ##1 !reg_req_in.wr ##1 ctl_rd |=>
    reg_rdata_out[1]) else $error("external flag not set");
  chk_global_off: assert property (
    ctl_wr && !wd[7] |=> ##1 !irq_out)
    else $error("request with global enable clear");
  chk_no_source: assert property (
    ctl_wr && wd[6:3] == 4'h0 |=> ##1 !irq_out)
    else $error("request with every source disabled");
  chk_irq_raise: assert property (
    ctl_wr && wd[7] && wd[3] && wd[0] |=> ##1 irq_out)
    else $error("no request for enabled set flag");
endmodule
bind interrupt_enable_flag_control irq_ctrl_checker #(
  .PORT_WIDTH(PORT_WIDTH), .HAS_CONVERTER(HAS_CONVERTER)
) u_irq_ctrl_checker (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_req_in(reg_req_in),
  .reg_rdata_out(reg_rdata_out), .events_in(events_in),
  .port_pins_in(port_pins_in), .irq_out(irq_out));

/* verif/irq_source_model.sv */
// event and port pin source standing in for the peripherals
`timescale 1ns/100ps
module irq_source_model
(
  input  wire logic                        ref_clk_in,
  output      irq_ctrl_pkg::irq_event_type events_out = '0,
  output      logic [5:0]                  pins_out = 6'h00
);
  // one-cycle event pulse launched after an edge
  task automatic pulse(input irq_ctrl_pkg::irq_event_type ev);
    @(posedge ref_clk_in);
    events_out <= ev;
    @(posedge ref_clk_in);
    events_out <= '0;
  endtask
  // new port level, held until the next call
  task automatic drive_pins(input logic [5:0] p);
    @(posedge ref_clk_in);
    pins_out <= p;
  endtask
endmodule

/* verif/interrupt_enable_flag_control_tb_top.sv */
// testbench for the interrupt enable and flag block
`timescale 1ns/100ps
module interrupt_enable_flag_control_tb_top;
  logic                        ref_clk_in;
  logic                        rst_n_in = 1'b0;
  irq_ctrl_pkg::reg_req_type   req = '0;
  logic [7:0]                  rdata;
  irq_ctrl_pkg::irq_event_type events;
  logic [5:0]                  pins;
  logic                        irq;
  int                          mismatches = 0;
  int                          check_count = 0;
  int                          cycles = 0;
  logic [7:0]                  pie_tab [4] = '{8'h80, 8'h40, 8'h08, 8'h01};
  interrupt_enable_flag_control u_interrupt_enable_flag_control (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .events_in(events), .port_pins_in(pins),
    .irq_out(irq));
  irq_source_model u_irq_source_model (.ref_clk_in(ref_clk_in),
    .events_out(events), .pins_out(pins));
  // bus tasks and comparison
  task automatic check(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk_in);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk_in);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, exp, input string nm);
    @(posedge ref_clk_in);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk_in);
    req <= '0;
    #1 check(nm, rdata, exp);
  endtask
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge ref_clk_in);
    #1 check("irq", {7'h00, irq}, {7'h00, exp});
  endtask
  task automatic end_sim;
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // clock and hang guard
  initial
  begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      end_sim();
    end
  end
  // main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd(8'h0B, 8'h00, "control reset");
    rd(8'h8C, 8'h00, "periph reset");
    wr(8'h8C, 8'hFF);
    rd(8'h8C, 8'hC9, "periph enable");
    rd(8'h55, 8'h00, "unmapped");
    u_irq_source_model.pulse(6'h30);
    rd(8'h0B, 8'h06, "flags no enable");
    wr(8'h8B, 8'h00);
    rd(8'h0B, 8'h00, "flags cleared");
    wr(8'h96, 8'h01);
    u_irq_source_model.drive_pins(6'h02);
    rd(8'h0B, 8'h00, "unselected pin");
    u_irq_source_model.drive_pins(6'h03);
    rd(8'h0B, 8'h01, "selected pin");
    wr(8'h0B, 8'h00);
    wr(8'h0B, 8'h88);
    irq_is(1'b0);
    u_irq_source_model.drive_pins(6'h02);
    irq_is(1'b1);
    wr(8'h0B, 8'h09);
    irq_is(1'b0);
    wr(8'h0B, 8'h89);
    irq_is(1'b1);
    wr(8'h0B, 8'hA0);
    u_irq_source_model.pulse(6'h20);
    irq_is(1'b1);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h8C, 8'h00);
      wr(8'h0B, 8'hC0);
      u_irq_source_model.pulse(6'h08 >> i);
      irq_is(1'b0);
      wr(8'h8C, pie_tab[i]);
      irq_is(1'b1);
      wr(8'h0B, 8'h80);
      irq_is(1'b0);
      wr(8'h0C, pie_tab[i]);
    end
    end_sim();
  end
endmodule
